/* common/ucc_pkg.sv */
// package for the unit conversion coefficient bank: map, resets, request types
package ucc_pkg;
   localparam int          ADDR_W          = 12;
   localparam int          COEFF_W         = 16;
   localparam int          RAW_W           = 32;
   localparam int          VIRT_W          = 64;
   localparam int          PROD_W          = RAW_W + COEFF_W;
   localparam int          MUL_LAT         = 2;
   localparam logic [11:0] VOLT_COEFF_OFS  = 12'h014;
   localparam logic [11:0] CURR_COEFF_OFS  = 12'h016;
   localparam logic [11:0] PWR_COEFF_OFS   = 12'h018;
   localparam logic [15:0] COEFF_RST       = 16'h0001;
   localparam logic [1:0]  RST_SYNC_INIT   = 2'h0;
   // quantity selects for a virtual read request
   typedef enum logic [3:0] {
      UCC_Q_VOLT, UCC_Q_CURR, UCC_Q_P, UCC_Q_Q, UCC_Q_S,
      UCC_Q_PF, UCC_Q_QF, UCC_Q_SF
   } ucc_qty_t;
   // channel 0..2 = phases A..C, 3 = neutral (current) or total (power)
   typedef struct packed {
      ucc_qty_t    qty;
      logic [1:0]  chan;
   } ucc_vreq_t;
   typedef struct packed {
      logic               valid;
      logic [VIRT_W-1:0]  value;
   } ucc_vrsp_t;
endpackage : ucc_pkg

/* rtl/ucc_mul.sv */
// signed raw value times unsigned coefficient, two pipeline stages
module ucc_mul #(
   parameter int RAW_W   = 32,
   parameter int COEFF_W = 16
) (
   input  wire logic                       clk_sys_i,   // system clock
   input  wire logic                       rst_n_i,     // synchronised reset
   input  wire logic                       go_i,        // operands valid
   input  wire logic signed [RAW_W-1:0]    raw_i,       // raw measurement
   input  wire logic [COEFF_W-1:0]         coeff_i,     // unsigned coefficient
   output logic                            done_o,      // product valid
   output logic signed [RAW_W+COEFF_W-1:0] prod_o       // full width product
);
   logic                               go_q;
   logic signed [RAW_W-1:0]            raw_q;
   logic signed [COEFF_W:0]            coeff_q;
   logic signed [RAW_W+COEFF_W:0]      prod_full;

   // operands widen to the full width before the multiply, so no high bits are lost
   assign prod_full = raw_q * coeff_q;

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         go_q    <= 1'b0;
         raw_q   <= '0;
         coeff_q <= '0;
      end else begin
         go_q    <= go_i;
         raw_q   <= raw_i;
         coeff_q <= $signed({1'b0, coeff_i});  // zero extend keeps it unsigned
      end
   end

   // full product width, no bits dropped
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_o <= 1'b0;
         prod_o <= '0;
      end else begin
         done_o <= go_q;
         prod_o <= prod_full[RAW_W+COEFF_W-1:0];
      end
   end
endmodule : ucc_mul

/* rtl/ucc_coeff_bank.sv */
// unit conversion coefficient bank with on-demand scaled virtual values
// Notes on behaviour
// - phase rms voltage is multiplied by the voltage coefficient on read.
// - three 16-bit coefficient registers, each resetting to one.
// - phase and neutral rms current multiplied by the current coefficient.
// - each raw per-phase power multiplied by the power coefficient.
// - power coefficient covers real, reactive, apparent, total and fundamental.
// - virtual value computed at request time, 8 bytes, lsb first.
module ucc_coeff_bank #(
   parameter int RAW_W = 32
) (
   input  wire logic                       clk_sys_i,    // 20 MHz system clock
   input  wire logic                       rstn_i,       // async reset, active low
   input  wire logic [ucc_pkg::ADDR_W-1:0] reg_addr_i,   // register address
   input  wire logic [15:0]                reg_wdata_i,  // write data
   input  wire logic                       reg_wr_i,     // write strobe
   input  wire logic                       reg_rd_i,     // read strobe
   output logic [15:0]                     reg_rdata_o,  // read data, cycle after strobe
   input  wire ucc_pkg::ucc_vreq_t         vreq_i,       // virtual read select
   input  wire logic                       vreq_valid_i, // virtual read request
   input  wire logic [4*RAW_W-1:0]         raw_rms_v_i,  // rms voltage, phases a..c
   input  wire logic [4*RAW_W-1:0]         raw_rms_i_i,  // rms current, a..c, neutral
   input  wire logic [4*RAW_W-1:0]         raw_p_i,      // real power a..c
   input  wire logic [4*RAW_W-1:0]         raw_q_i,      // reactive power a..c
   input  wire logic [4*RAW_W-1:0]         raw_s_i,      // apparent power a..c
   input  wire logic [4*RAW_W-1:0]         raw_pf_i,     // fundamental real a..c
   input  wire logic [4*RAW_W-1:0]         raw_qf_i,     // fundamental reactive a..c
   input  wire logic [4*RAW_W-1:0]         raw_sf_i,     // fundamental apparent a..c
   output ucc_pkg::ucc_vrsp_t              vrsp_o,       // scaled virtual answer
   output logic                            vbusy_o       // request in flight
);
   localparam int PW = RAW_W + ucc_pkg::COEFF_W;

   typedef enum logic [1:0] {UCC_IDLE, UCC_SUM, UCC_MUL} ucc_state_t;

   logic [1:0]              rst_sync_q;
   logic                    rst_n;
   logic [15:0]             volt_coeff_q;
   logic [15:0]             curr_coeff_q;
   logic [15:0]             pwr_coeff_q;
   ucc_state_t              state_q;
   ucc_pkg::ucc_vreq_t      req_q;
   logic [1:0]              idx_q;
   logic signed [PW+1:0]    acc_q;
   logic signed [PW+1:0]    sum;
   logic [4*RAW_W-1:0]      raw_bus;
   logic signed [RAW_W-1:0] lane [4];
   logic [15:0]             coeff;
   logic signed [RAW_W-1:0] raw_sel;
   logic                    is_total;
   logic                    vreq_is_total;
   logic                    take;
   logic                    more_lanes;
   logic                    last_done;
   logic                    go_q;
   logic                    mul_done;
   logic signed [PW-1:0]    prod;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) rst_sync_q <= ucc_pkg::RST_SYNC_INIT;
      else         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // coefficient registers; values below 1000 are accepted, precision is the software's concern
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         volt_coeff_q <= ucc_pkg::COEFF_RST;
      end else if (reg_wr_i && reg_addr_i == ucc_pkg::VOLT_COEFF_OFS) begin
         volt_coeff_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         curr_coeff_q <= ucc_pkg::COEFF_RST;
      end else if (reg_wr_i && reg_addr_i == ucc_pkg::CURR_COEFF_OFS) begin
         curr_coeff_q <= reg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         pwr_coeff_q <= ucc_pkg::COEFF_RST;
      end else if (reg_wr_i && reg_addr_i == ucc_pkg::PWR_COEFF_OFS) begin
         pwr_coeff_q <= reg_wdata_i;
      end
   end

   // read port, unmapped addresses read zero
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            ucc_pkg::VOLT_COEFF_OFS: reg_rdata_o <= volt_coeff_q;
            ucc_pkg::CURR_COEFF_OFS: reg_rdata_o <= curr_coeff_q;
            ucc_pkg::PWR_COEFF_OFS:  reg_rdata_o <= pwr_coeff_q;
            default:                 reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // operand select at request time
   always_comb begin
      raw_bus = raw_p_i;
      coeff   = pwr_coeff_q;
      case (req_q.qty)
         ucc_pkg::UCC_Q_VOLT: begin
            raw_bus = raw_rms_v_i;
            coeff   = volt_coeff_q;
         end
         ucc_pkg::UCC_Q_CURR: begin
            raw_bus = raw_rms_i_i;
            coeff   = curr_coeff_q;
         end
         ucc_pkg::UCC_Q_Q:  raw_bus = raw_q_i;
         ucc_pkg::UCC_Q_S:  raw_bus = raw_s_i;
         ucc_pkg::UCC_Q_PF: raw_bus = raw_pf_i;
         ucc_pkg::UCC_Q_QF: raw_bus = raw_qf_i;
         ucc_pkg::UCC_Q_SF: raw_bus = raw_sf_i;
         default:           raw_bus = raw_p_i;
      endcase
   end

   // lane k of a raw bus is phase k, lane 3 the neutral current
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign lane[g] = $signed(raw_bus[g*RAW_W +: RAW_W]);
   end
   assign raw_sel = lane[idx_q];

   // power totals have no raw source; they are the sum of the three phases
   assign is_total      = (req_q.qty != ucc_pkg::UCC_Q_VOLT)
                          && (req_q.qty != ucc_pkg::UCC_Q_CURR)
                          && (req_q.chan == 2'h3);
   assign vreq_is_total = (vreq_i.qty != ucc_pkg::UCC_Q_VOLT)
                          && (vreq_i.qty != ucc_pkg::UCC_Q_CURR)
                          && (vreq_i.chan == 2'h3);

   // a request is taken only while idle; one offered while busy is dropped
   assign take       = (state_q == UCC_IDLE) && vreq_valid_i;
   assign more_lanes = is_total && (idx_q != 2'h2);
   assign last_done  = (state_q == UCC_MUL) && mul_done && !more_lanes;
   assign sum        = acc_q + (PW+2)'(prod);

   ucc_mul #(
      .RAW_W   (RAW_W),
      .COEFF_W (ucc_pkg::COEFF_W)
   ) u_mul (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .go_i      (go_q),
      .raw_i     (raw_sel),
      .coeff_i   (coeff),
      .done_o    (mul_done),
      .prod_o    (prod)
   );

   // request sequencer; each product is taken when it is asked for
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= UCC_IDLE;
      end else begin
         case (state_q)
            UCC_IDLE: begin
               if (take) begin
                  state_q <= UCC_MUL;
               end
            end
            UCC_MUL: begin
               if (mul_done) begin
                  state_q <= more_lanes ? UCC_SUM : UCC_IDLE;
               end
            end
            UCC_SUM: begin
               state_q <= UCC_MUL;
            end
            default: state_q <= UCC_IDLE;
         endcase
      end
   end

   // request capture and lane walk; a total starts at phase a
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         req_q <= '0;
         idx_q <= '0;
      end else if (take) begin
         req_q <= vreq_i;
         idx_q <= vreq_is_total ? 2'h0 : vreq_i.chan;
      end else if (state_q == UCC_MUL && mul_done && more_lanes) begin
         idx_q <= idx_q + 2'h1;
      end
   end

   // two guard bits so a three phase sum cannot overflow
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         acc_q <= '0;
      end else if (take) begin
         acc_q <= '0;
      end else if (state_q == UCC_MUL && mul_done) begin
         acc_q <= sum;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         go_q <= 1'b0;
      end else begin
         go_q <= take || (state_q == UCC_SUM);
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         vbusy_o <= 1'b0;
      end else if (take) begin
         vbusy_o <= 1'b1;
      end else if (last_done) begin
         vbusy_o <= 1'b0;
      end
   end

   // sign extended to 64 bits, sent lsb first by the serial side
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         vrsp_o <= '0;
      end else begin
         vrsp_o.valid <= last_done;
         if (last_done) begin
            vrsp_o.value <= ucc_pkg::VIRT_W'(sum);
         end
      end
   end
endmodule : ucc_coeff_bank

/* testbench/ucc_coeff_bank_monitor.sv */
// timing checker for the coefficient bank register port and virtual answers
module ucc_coeff_bank_monitor (
   input wire logic [ucc_pkg::ADDR_W-1:0] reg_addr_i,   // register address
   input wire logic                       clk_sys_i,    // system clock
   input wire logic                       rstn_i,       // async reset, active low
   input wire logic [15:0]                reg_wdata_i,  // write data
   input wire logic                       reg_wr_i,     // write strobe
   input wire logic                       reg_rd_i,     // read strobe
   input wire logic [15:0]                reg_rdata_o,  // read data
   input wire ucc_pkg::ucc_vreq_t         vreq_i,       // request select
   input wire logic                       vreq_valid_i, // request strobe
   input wire ucc_pkg::ucc_vrsp_t         vrsp_o,       // scaled answer
   input wire logic                       vbusy_o       // request in flight
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   logic take;
   logic ptot;
   logic wr_volt;
   logic rd_volt;
   assign take = vreq_valid_i && !vbusy_o;
   assign wr_volt = reg_wr_i && reg_addr_i == ucc_pkg::VOLT_COEFF_OFS;
   assign rd_volt = reg_rd_i && reg_addr_i == ucc_pkg::VOLT_COEFF_OFS;
   // power totals sum three products, so they take the long path
   assign ptot = take && vreq_i.chan == 2'h3 && vreq_i.qty > ucc_pkg::UCC_Q_CURR;
   a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data not idle");
   a_wr_readback: assert property (wr_volt ##1 !reg_wr_i ##1 rd_volt
      |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("coefficient readback wrong");
   a_busy_span: assert property (take && !ptot |=> vbusy_o [*3] ##1 !vbusy_o)
      else $error("busy span wrong");
   a_phase_lat: assert property (take && !ptot |-> ##4 vrsp_o.valid)
      else $error("phase answer late");
   a_total_lat: assert property (ptot |-> ##12 vrsp_o.valid)
      else $error("total answer late");
   a_valid_pulse: assert property (vrsp_o.valid |=> !vrsp_o.valid)
      else $error("valid longer than one cycle");
   a_value_hold: assert property (!vrsp_o.valid |-> $stable(vrsp_o.value))
      else $error("answer value moved");
   a_valid_cause: assert property (vrsp_o.valid |-> $past(vbusy_o))
      else $error("answer without request");
   c_total: cover property (ptot);
   c_volt: cover property (take && vreq_i.qty == ucc_pkg::UCC_Q_VOLT);
   c_refused: cover property (vreq_valid_i && vbusy_o);
endmodule : ucc_coeff_bank_monitor

bind ucc_coeff_bank ucc_coeff_bank_monitor u_mon (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i,
   .reg_wr_i, .reg_rd_i, .reg_rdata_o, .vreq_i, .vreq_valid_i, .vrsp_o, .vbusy_o);

/* testbench/test_ucc_coeff_bank.sv */
// self-checking bench for the coefficient bank
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_ucc_coeff_bank;
   timeunit 1ns;
   timeprecision 1ns;
   logic               clk_sys_i = 1'b0;
   logic               rstn_i = 1'b0;
   logic [11:0]        reg_addr_i = 12'h000;
   logic [15:0]        reg_wdata_i = 16'h0000;
   logic               reg_wr_i = 1'b0;
   logic               reg_rd_i = 1'b0;
   logic [15:0]        reg_rdata_o;
   ucc_pkg::ucc_vreq_t vreq_i = '0;
   logic               vreq_valid_i = 1'b0;
   logic [127:0]       raw_q [8] = '{default: '0};
   ucc_pkg::ucc_vrsp_t vrsp_o;
   logic               vbusy_o;
   int                 n_errors = 0;
   int                 n_compared = 0;
   int                 cycles = 0;
   int                 coef [3] = '{1, 1, 1};
   always #25 clk_sys_i = ~clk_sys_i;
   ucc_coeff_bank uut (.clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .vreq_i, .vreq_valid_i, .raw_rms_v_i(raw_q[0]), .raw_rms_i_i(raw_q[1]),
      .raw_p_i(raw_q[2]), .raw_q_i(raw_q[3]), .raw_s_i(raw_q[4]), .raw_pf_i(raw_q[5]),
      .raw_qf_i(raw_q[6]), .raw_sf_i(raw_q[7]), .vrsp_o, .vbusy_o);
   // model: lane product with the unsigned coefficient, totals sum phases a..c
   function automatic logic [63:0] exp_val(input int q, input int c);
      longint acc;
      int k;
      acc = 0;
      k = (q > 1) ? 2 : q;
      for (int l = 0; l < 4; l++) begin
         if ((c == 3 && q > 1) ? (l < 3) : (l == c))
            acc += longint'($signed(raw_q[q][32*l +: 32])) * coef[k];
      end
      return acc;
   endfunction : exp_val
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      for (int k = 0; k < 3; k++) if (a == 12'h014 + 12'(2*k)) coef[k] = d;
      @(posedge clk_sys_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_sys_i);
      reg_rd_i <= 1'b0;
      #1 `CHK(reg_rdata_o, e)
   endtask : rd
   // poke sends a second request while busy, which must be dropped
   task automatic vq(input int q, input int c, input bit poke);
      int w;
      w = 0;
      @(posedge clk_sys_i);
      foreach (raw_q[i]) raw_q[i] <= {$urandom, $urandom, $urandom, $urandom};
      vreq_valid_i <= 1'b1;
      vreq_i <= '{ucc_pkg::ucc_qty_t'(q), 2'(c)};
      @(posedge clk_sys_i);
      vreq_valid_i <= poke;
      vreq_i.chan <= 2'(c + 1);
      @(posedge clk_sys_i);
      vreq_valid_i <= 1'b0;
      do begin
         @(posedge clk_sys_i);
         #1 w++;
      end while (vrsp_o.valid !== 1'b1 && w < 40);
      `CHK(vrsp_o.valid, 1'b1)
      `CHK(vrsp_o.value, exp_val(q, c))
   endtask : vq
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         final_report;
      end
   end
   initial begin
      logic [15:0] d;
      void'($urandom(25));
      repeat (4) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      for (int k = 0; k < 3; k++) rd(12'h014 + 12'(2*k), 16'h0001);
      wr(12'h01A, 16'hFFFF);
      rd(12'h01A, 16'h0000);
      // pass 2 uses the largest coefficient to expose a narrow product
      for (int p = 0; p < 3; p++) begin
         for (int k = 0; k < 3 && p > 0; k++) begin
            d = (p == 2) ? 16'hFFFF : 16'($urandom_range(65535, 1001));
            wr(12'h014 + 12'(2*k), d);
            rd(12'h014 + 12'(2*k), d);
         end
         for (int q = 0; q < 8; q++)
            for (int c = 0; c < 4; c++) vq(q, c, (q + c) % 3 == 0);
      end
      final_report;
   end
endmodule : test_ucc_coeff_bank
